/* File: design/wdcfg_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdcfg_map.svh"

module wdcfg_top #(
   parameter int unsigned TICK_CYCLES = `WDCFG_CLK_HZ,
   parameter int unsigned FAST_CYCLES = `WDCFG_FAST_CYC,
   parameter int unsigned SLOW_CYCLES = `WDCFG_SLOW_CYC,
   parameter int unsigned SLOW_FW_CYCLES = `WDCFG_SLOW_FW_CYC,
   parameter int unsigned CRC_CYCLES = `WDCFG_CRC_MIN_CYC,
   parameter logic [15:0] JUMPER_MASK = 16'h0000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic resp_sent,
   input wire logic stream_sent,
   input wire logic wd_enable,
   input wire logic [31:0] wd_timeout_s,
   input wire logic [31:0] wd_advanced,
   input wire logic fw_updated,
   input wire wdcfg_pkg::wdcfg_set_t live_in,
   input wire wdcfg_pkg::wdcfg_set_t factory_set,
   input wire wdcfg_pkg::wdcfg_set_t nv_default_in,
   output wdcfg_pkg::wdcfg_set_t nv_default_out,
   output logic nv_default_wr,
   output wdcfg_pkg::wdcfg_set_t live_out,
   output logic live_wr,
   output logic [15:0] line_dir_out,
   output logic [15:0] line_level_out,
   output logic wd_expired,
   output logic wd_in_boot
);

   logic [31:0] boot_tmo;
   logic key_en;
   logic [31:0] key_val;
   logic clear_req;
   logic [31:0] tick_cnt;
   logic sec_tick;
   logic [31:0] sec_cnt;
   logic [31:0] active_tmo;
   logic expire;
   logic wr_hit_clear;
   wdcfg_pkg::wdcfg_boot_t boot_state;
   logic [31:0] boot_cnt;
   logic [31:0] slow_limit;
   logic crc_busy;
   logic [31:0] crc_cnt;
   logic [47:0] crc_data;
   logic [6:0] crc_bit;
   logic [31:0] crc_reg;
   logic [31:0] next_crc;
   logic read_pending;

   assign wr_hit_clear = reg_wr && reg_addr == `WDCFG_ADDR_CLEAR;

   // Watchdog settings are only changed while it is disabled.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_tmo <= 32'h0000_0000;
         key_en <= 1'b0;
         key_val <= 32'h0000_0000;
      end else if (reg_wr && !wd_enable) begin
         case (reg_addr)
            `WDCFG_ADDR_BOOT_TMO: boot_tmo <= reg_wdata;
            `WDCFG_ADDR_KEY_EN: key_en <= reg_wdata == `WDCFG_CMD_GO;
            `WDCFG_ADDR_KEY: key_val <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Stream traffic is deliberately absent from the clear terms.
   always_comb begin
      if (key_en) begin
         clear_req = wr_hit_clear && reg_wdata == key_val;
      end else begin
         clear_req = wr_hit_clear || resp_sent;
      end
   end

   // The tick counter restarts on clear so a clear buys a full second.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 32'h0000_0000;
         sec_tick <= 1'b0;
      end else if (clear_req || !wd_enable) begin
         tick_cnt <= 32'h0000_0000;
         sec_tick <= 1'b0;
      end else if (tick_cnt == TICK_CYCLES - 1) begin
         tick_cnt <= 32'h0000_0000;
         sec_tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         sec_tick <= 1'b0;
      end
   end

   // The boot value is picked by the flag alone; a zero timeout expires on
   // the first tick.
   assign active_tmo = wd_in_boot ? boot_tmo : wd_timeout_s;

   // A clear that lands on the tick edge wins, so a host that clears just
   // in time never triggers the timeout actions.
   always_comb begin
      expire = 1'b0;
      if (wd_enable && sec_tick && !clear_req) begin
         if (sec_cnt + 32'h0000_0001 >= active_tmo) begin
            expire = 1'b1;
         end
      end
   end

   // An expiry restarts the count, so a silent host sees the actions
   // repeat once per timeout period.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt <= 32'h0000_0000;
         wd_expired <= 1'b0;
      end else begin
         wd_expired <= expire;
         if (clear_req || expire || !wd_enable) begin
            sec_cnt <= 32'h0000_0000;
         end else if (sec_tick) begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
         end
      end
   end

   // Boot timeout is left on the first clear or expiry while enabled.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_in_boot <= 1'b1;
      end else if (wd_enable && (clear_req || expire)) begin
         wd_in_boot <= 1'b0;
      end
   end

   // Commands to the configuration store.
   // Only the value 1 starts a command; any other value is ignored.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_default_out <= '0;
         nv_default_wr <= 1'b0;
      end else begin
         nv_default_wr <= 1'b0;
         if (reg_wr && reg_wdata == `WDCFG_CMD_GO) begin
            if (reg_addr == `WDCFG_ADDR_SAVE_CUR) begin
               nv_default_out <= live_in;
               nv_default_wr <= 1'b1;
            end else if (reg_addr == `WDCFG_ADDR_SAVE_FAC) begin
               nv_default_out <= factory_set;
               nv_default_wr <= 1'b1;
            end
         end
      end
   end

   // Expiry actions share the load path with the host commands.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_out <= '0;
         live_wr <= 1'b0;
      end else begin
         live_wr <= 1'b0;
         if ((reg_wr && reg_addr == `WDCFG_ADDR_LOAD_FAC
              && reg_wdata == `WDCFG_CMD_GO)
             || (expire && wd_advanced[`WDCFG_ADV_LOAD_FAC])) begin
            live_out <= factory_set;
            live_wr <= 1'b1;
         end else if ((reg_wr && reg_addr == `WDCFG_ADDR_LOAD_DEF
                       && reg_wdata == `WDCFG_CMD_GO)
                      || (expire && wd_advanced[`WDCFG_ADV_LOAD_DEF])
                      || (boot_state == wdcfg_pkg::WDCFG_BOOT_WAIT_SLOW
                          && boot_cnt == slow_limit - 1)) begin
            live_out <= nv_default_in;
            live_wr <= 1'b1;
         end
      end
   end

   // Power-up sequencing of the stored defaults.
   assign slow_limit = fw_updated ? SLOW_FW_CYCLES : SLOW_CYCLES;

   // The counter freezes once boot is over, so it cannot wrap and replay
   // the startup loads.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_state <= wdcfg_pkg::WDCFG_BOOT_WAIT_FAST;
         boot_cnt <= 32'h0000_0000;
      end else begin
         boot_cnt <= boot_cnt + 32'h0000_0001;
         case (boot_state)
            wdcfg_pkg::WDCFG_BOOT_WAIT_FAST:
               if (boot_cnt == FAST_CYCLES - 1) begin
                  boot_state <= wdcfg_pkg::WDCFG_BOOT_WAIT_SLOW;
               end
            wdcfg_pkg::WDCFG_BOOT_WAIT_SLOW:
               if (boot_cnt == slow_limit - 1) begin
                  boot_state <= wdcfg_pkg::WDCFG_BOOT_DONE;
               end
            wdcfg_pkg::WDCFG_BOOT_DONE: boot_cnt <= boot_cnt;
            default: boot_state <= wdcfg_pkg::WDCFG_BOOT_DONE;
         endcase
      end
   end

   // Digital lines are inputs until their group of defaults is applied.
   // Jumper lines wait for the slow group so a boot jumper is not driven.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_dir_out <= 16'h0000;
         line_level_out <= 16'h0000;
      end else if (live_wr) begin
         line_dir_out <= live_out.dir;
         line_level_out <= live_out.level;
      end else begin
         case (boot_state)
            wdcfg_pkg::WDCFG_BOOT_WAIT_FAST:
               if (boot_cnt == FAST_CYCLES - 1) begin
                  line_dir_out <= nv_default_in.dir & ~JUMPER_MASK;
                  line_level_out <= nv_default_in.level & ~JUMPER_MASK;
               end
            wdcfg_pkg::WDCFG_BOOT_WAIT_SLOW:
               if (boot_cnt == slow_limit - 1) begin
                  line_dir_out <= nv_default_in.dir;
                  line_level_out <= nv_default_in.level;
               end
            default: ;
         endcase
      end
   end

   // Serial CRC over the steady settings, one bit per clock.
   always_comb begin
      next_crc = {crc_reg[30:0], 1'b0};
      if (crc_reg[31] ^ crc_data[47]) begin
         next_crc = next_crc ^ `WDCFG_CRC_POLY;
      end
   end

   // The answer is held back to a fixed floor so every checksum read taken while idle sees 5 ms.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_busy <= 1'b0;
         crc_cnt <= 32'h0000_0000;
         crc_data <= '0;
         crc_bit <= 7'h00;
         crc_reg <= `WDCFG_CRC_INIT;
      end else if (!crc_busy) begin
         if (reg_rd && reg_addr == `WDCFG_ADDR_CRC) begin
            crc_busy <= 1'b1;
            crc_cnt <= 32'h0000_0000;
            crc_data <= {live_in.analog, live_in.in_ext,
                         live_in.line_ext};
            crc_bit <= 7'h00;
            crc_reg <= `WDCFG_CRC_INIT;
         end
      end else begin
         crc_cnt <= crc_cnt + 32'h0000_0001;
         // The 48 message bits finish long before the floor, so the
         // register idles until the answer is released.
         if (crc_bit != 7'h30) begin
            crc_reg <= next_crc;
            crc_data <= {crc_data[46:0], 1'b0};
            crc_bit <= crc_bit + 7'h01;
         end
         if (crc_cnt == CRC_CYCLES - 1) begin
            crc_busy <= 1'b0;
         end
      end
   end

   // The checksum answer goes out ahead of any other read; reads that land
   // while the job runs are dropped with no strobe.
   assign read_pending = crc_busy && crc_cnt == CRC_CYCLES - 1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= 1'b0;
         if (read_pending) begin
            reg_rdata <= ~crc_reg;
            reg_rvalid <= 1'b1;
         end else if (reg_rd && !crc_busy) begin
            case (reg_addr)
               `WDCFG_ADDR_BOOT_TMO: begin
                  reg_rdata <= boot_tmo;
                  reg_rvalid <= 1'b1;
               end
               `WDCFG_ADDR_KEY_EN: begin
                  reg_rdata <= {31'h0, key_en};
                  reg_rvalid <= 1'b1;
               end
               `WDCFG_ADDR_KEY: begin
                  reg_rdata <= key_val;
                  reg_rvalid <= 1'b1;
               end
               `WDCFG_ADDR_CRC: ;
               default: begin
                  reg_rdata <= 32'h0000_0000;
                  reg_rvalid <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* File: design/wdcfg_map.svh */
`ifndef WDCFG_MAP_SVH
`define WDCFG_MAP_SVH

`define WDCFG_ADDR_SAVE_CUR 16'hbf6a
`define WDCFG_ADDR_SAVE_FAC 16'hbf6c
`define WDCFG_ADDR_CRC 16'hbf7c
`define WDCFG_ADDR_BOOT_TMO 16'hf0a6
`define WDCFG_ADDR_KEY_EN 16'hf0aa
`define WDCFG_ADDR_KEY 16'hf0ac
`define WDCFG_ADDR_CLEAR 16'hf0ae
`define WDCFG_ADDR_LOAD_FAC 16'hf226
`define WDCFG_ADDR_LOAD_DEF 16'hf227

`define WDCFG_CMD_GO 32'h0000_0001
`define WDCFG_ADV_LOAD_FAC 0
`define WDCFG_ADV_LOAD_DEF 1
`define WDCFG_CRC_POLY 32'h04c1_1db7
`define WDCFG_CRC_INIT 32'hffff_ffff

`define WDCFG_CLK_HZ 20000000
`define WDCFG_CRC_MIN_US 5000
`define WDCFG_CRC_MAX_US 15000
`define WDCFG_FAST_US 2500
`define WDCFG_SLOW_MS 700
`define WDCFG_SLOW_FW_MS 12000
`define WDCFG_CRC_MIN_CYC ((`WDCFG_CLK_HZ / 1000000) * `WDCFG_CRC_MIN_US)
`define WDCFG_FAST_CYC ((`WDCFG_CLK_HZ / 1000000) * `WDCFG_FAST_US)
`define WDCFG_SLOW_CYC ((`WDCFG_CLK_HZ / 1000) * `WDCFG_SLOW_MS)
`define WDCFG_SLOW_FW_CYC ((`WDCFG_CLK_HZ / 1000) * `WDCFG_SLOW_FW_MS)

`endif

/* File: design/wdcfg_pkg.sv */
package wdcfg_pkg;

   typedef struct packed {
      logic [15:0] analog;
      logic [15:0] in_ext;
      logic [15:0] line_ext;
      logic [15:0] dir;
      logic [15:0] level;
      logic [15:0] dac;
   } wdcfg_set_t;

   typedef enum {
      WDCFG_BOOT_WAIT_FAST,
      WDCFG_BOOT_WAIT_SLOW,
      WDCFG_BOOT_DONE
   } wdcfg_boot_t;

endpackage

/* File: verif/wdcfg_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdcfg_map.svh"
module wdcfg_checker #(
   parameter int unsigned FAST_CYCLES = 20,
   parameter int unsigned CRC_CYCLES = 100
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic wd_enable,
   input wire wdcfg_pkg::wdcfg_set_t factory_set,
   input wire wdcfg_pkg::wdcfg_set_t nv_default_in,
   input wire wdcfg_pkg::wdcfg_set_t live_out,
   input wire logic live_wr,
   input wire logic [15:0] line_dir_out,
   input wire logic wd_expired,
   input wire logic wd_in_boot
);
   logic [15:0] up;
   logic [31:0] crc_n;
   logic go;
   assign go = reg_wr && reg_wdata == `WDCFG_CMD_GO;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) up <= 16'h0000;
      else if (up != 16'hffff) up <= up + 16'h0001;
   end
   // Mirrors the checksum job, so reads dropped while busy are not judged.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) crc_n <= 32'h0000_0000;
      else if (crc_n != 32'h0000_0000) crc_n <= crc_n - 32'h0000_0001;
      else if (reg_rd && reg_addr == `WDCFG_ADDR_CRC)
         crc_n <= 32'(CRC_CYCLES);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_key_wr;
      reg_wr && reg_addr == `WDCFG_ADDR_KEY && !wd_enable;
   endsequence
   sequence s_key_rd;
      reg_rd && reg_addr == `WDCFG_ADDR_KEY && crc_n == 32'h0000_0000;
   endsequence
   chk_key_readback: assert property (
      s_key_wr ##2 s_key_rd |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3))
      else $error("key register did not read back");
   chk_crc_quiet: assert property (crc_n > 32'h0000_0002 |-> !reg_rvalid)
      else $error("checksum answered too early");
   chk_crc_answer: assert property (
      crc_n == 32'h0000_0001 |-> ##[1:2] reg_rvalid)
      else $error("checksum answer missing");
   chk_load_factory: assert property (
      go && reg_addr == `WDCFG_ADDR_LOAD_FAC
      |=> live_wr && live_out == $past(factory_set))
      else $error("factory set not loaded");
   chk_load_default: assert property (
      go && reg_addr == `WDCFG_ADDR_LOAD_DEF
      |=> live_wr && live_out == $past(nv_default_in))
      else $error("stored defaults not loaded");
   chk_expire_pulse: assert property (wd_expired |=> !wd_expired)
      else $error("expiry pulse too long");
   chk_boot_leave: assert property (wd_expired |=> !wd_in_boot)
      else $error("boot timeout kept after expiry");
   chk_early_inputs: assert property (
      up < 16'(FAST_CYCLES - 2) |-> line_dir_out == 16'h0000)
      else $error("line driven before startup settings");
endmodule
bind wdcfg_top wdcfg_checker #(
   .FAST_CYCLES(FAST_CYCLES),
   .CRC_CYCLES(CRC_CYCLES)
) wdcfg_checker_i (
   .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .reg_rvalid, .wd_enable, .factory_set, .nv_default_in, .live_out,
   .live_wr, .line_dir_out, .wd_expired, .wd_in_boot
);
`default_nettype wire

/* File: verif/wdcfg_store.sv */
`timescale 1ns/1ns
`default_nettype none
module wdcfg_store #(
   parameter wdcfg_pkg::wdcfg_set_t NV_INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire wdcfg_pkg::wdcfg_set_t nv_default_out,
   input wire logic nv_default_wr,
   input wire wdcfg_pkg::wdcfg_set_t live_out,
   input wire logic live_wr,
   output var wdcfg_pkg::wdcfg_set_t nv_default_in,
   output var wdcfg_pkg::wdcfg_set_t live_in
);
   // Flash ignores reset, so stored defaults survive it.
   initial nv_default_in = NV_INIT;
   always @(posedge clk) begin
      if (nv_default_wr) nv_default_in <= nv_default_out;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) live_in <= '0;
      else if (live_wr) live_in <= live_out;
   end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdcfg_map.svh"
module tb;
   localparam int CRC = 100;
   localparam logic [15:0] JMP = 16'h000f;
   localparam wdcfg_pkg::wdcfg_set_t FAC = 96'h1111_2222_3333_00f0_0f0f_0abc;
   localparam wdcfg_pkg::wdcfg_set_t NVI = 96'ha1a1_b2b2_c3c3_00ff_0055_0123;
   logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, resp_sent, stream_sent;
   logic wd_enable, fw_updated, nv_default_wr, live_wr, wd_expired;
   logic wd_in_boot;
   logic [15:0] reg_addr, line_dir_out, line_level_out, ca [5];
   logic [31:0] reg_wdata, reg_rdata, wd_timeout_s, wd_advanced, d;
   wdcfg_pkg::wdcfg_set_t live_in, factory_set, nv_default_in;
   wdcfg_pkg::wdcfg_set_t nv_default_out, live_out;
   int n_mismatch, n_tests, n_exp, cyc, rd_n;
   wdcfg_top #(.TICK_CYCLES(10), .FAST_CYCLES(20), .SLOW_CYCLES(50),
      .SLOW_FW_CYCLES(80), .CRC_CYCLES(CRC), .JUMPER_MASK(JMP)) wdcfg_top_i (
      .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .resp_sent, .stream_sent, .wd_enable, .wd_timeout_s,
      .wd_advanced, .fw_updated, .live_in, .factory_set, .nv_default_in,
      .nv_default_out, .nv_default_wr, .live_out, .live_wr, .line_dir_out,
      .line_level_out, .wd_expired, .wd_in_boot);
   wdcfg_store #(.NV_INIT(NVI)) wdcfg_store_i (.clk, .rst_n,
      .nv_default_out, .nv_default_wr, .live_out, .live_wr, .nv_default_in,
      .live_in);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // The whole run needs about 610 cycles; 3000 leaves room for slow paths.
   always @(posedge clk) begin
      if (wd_expired === 1'b1) n_exp++;
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmpw(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t word %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmps(input wdcfg_pkg::wdcfg_set_t got,
      input wdcfg_pkg::wdcfg_set_t exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t set %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      rd_n = 0;
      #1;
      while (reg_rvalid !== 1'b1 && rd_n < 400) begin
         @(posedge clk);
         #1;
         rd_n++;
      end
      d = reg_rdata;
   endtask
   // Expiries before the first candidate are ignored: the timer may start
   // close to its limit.
   task automatic keep(input int kind, input logic [31:0] v, input logic ex);
      int e0;
      for (int i = 0; i < 7; i++) begin
         repeat (6) @(posedge clk);
         if (kind == 2) begin
            wr_reg(`WDCFG_ADDR_CLEAR, v);
         end else begin
            resp_sent <= kind == 0;
            stream_sent <= kind == 1;
            @(posedge clk);
            resp_sent <= 1'b0;
            stream_sent <= 1'b0;
         end
         if (i == 0) e0 = n_exp;
      end
      cmpw({31'h0, n_exp != e0}, {31'h0, ex});
   endtask
   function automatic logic [31:0] crc_of(input logic [47:0] m);
      logic [31:0] c;
      c = `WDCFG_CRC_INIT;
      for (int i = 47; i >= 0; i--)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ m[i]) ? `WDCFG_CRC_POLY : 32'h0);
      return ~c;
   endfunction
   initial begin
      {rst_n, reg_wr, reg_rd, resp_sent, stream_sent, wd_enable} = 6'h00;
      fw_updated = 1'b0;
      {reg_addr, reg_wdata, wd_advanced} = 80'h0;
      wd_timeout_s = 32'h0000_0003;
      factory_set = FAC;
      ca = '{`WDCFG_ADDR_LOAD_FAC, `WDCFG_ADDR_LOAD_FAC, `WDCFG_ADDR_LOAD_DEF,
         `WDCFG_ADDR_SAVE_FAC, `WDCFG_ADDR_SAVE_CUR};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      cmpw({16'h0, line_dir_out}, 32'h0);
      cmpw({31'h0, wd_in_boot}, 32'h1);
      repeat (25) @(posedge clk);
      #1;
      cmpw({16'h0, line_dir_out}, {16'h0, NVI.dir & ~JMP});
      cmpw({16'h0, line_level_out}, {16'h0, NVI.level & ~JMP});
      repeat (30) @(posedge clk);
      #1;
      cmpw({16'h0, line_dir_out}, {16'h0, NVI.dir});
      cmpw({16'h0, line_level_out}, {16'h0, NVI.level});
      cmps(live_in, NVI);
      $display("test boot done");
      wr_reg(`WDCFG_ADDR_KEY_EN, 32'h0);
      wr_reg(`WDCFG_ADDR_BOOT_TMO, 32'h3);
      wr_reg(`WDCFG_ADDR_KEY, 32'hc0de_5eed);
      rd_reg(`WDCFG_ADDR_KEY);
      cmpw(d, 32'hc0de_5eed);
      rd_reg(16'h0010);
      cmpw(d, 32'h0);
      rd_reg(`WDCFG_ADDR_CLEAR);
      cmpw(d, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr_reg(ca[i], i == 0 ? 32'h2 : 32'h1);
         repeat (2) @(posedge clk);
         cmps(live_in, i == 1 ? FAC : NVI);
         cmps(nv_default_in, i == 3 ? FAC : NVI);
      end
      wr_reg(`WDCFG_ADDR_LOAD_FAC, 32'h1);
      rd_reg(`WDCFG_ADDR_CRC);
      cmpw(d, crc_of(FAC[95:48]));
      cmpw({31'h0, rd_n >= CRC && rd_n <= 3 * CRC}, 32'h1);
      $display("test config done");
      wr_reg(`WDCFG_ADDR_LOAD_DEF, 32'h1);
      wd_advanced <= 32'h1;
      wd_enable <= 1'b1;
      keep(0, 32'h0, 1'b0);
      cmpw({31'h0, wd_in_boot}, 32'h0);
      keep(1, 32'h0, 1'b1);
      cmps(live_in, FAC);
      keep(2, 32'h5a, 1'b0);
      @(posedge clk);
      wd_enable <= 1'b0;
      wr_reg(`WDCFG_ADDR_KEY_EN, 32'h1);
      wd_advanced <= 32'h2;
      wd_enable <= 1'b1;
      keep(0, 32'h0, 1'b1);
      cmps(live_in, NVI);
      keep(2, 32'h5a, 1'b1);
      keep(2, 32'hc0de_5eed, 1'b0);
      $display("test watchdog done");
      // Second power-up after a firmware update: the slow group comes late.
      wd_enable <= 1'b0;
      fw_updated <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (60) @(posedge clk);
      #1;
      cmpw({16'h0, line_dir_out}, {16'h0, NVI.dir & ~JMP});
      cmps(live_in, 96'h0);
      repeat (25) @(posedge clk);
      #1;
      cmpw({16'h0, line_dir_out}, {16'h0, NVI.dir});
      cmps(live_in, NVI);
      $display("test update boot done");
      give_verdict();
   end
endmodule
`default_nettype wire
